// [hdl/spi_eeprom_pkg.sv]
// Constants and carrier types for the serial nonvolatile memory front end
package spi_eeprom_pkg;

   // Timing
   localparam int unsigned clk_period_ns = 20;
   localparam int unsigned write_time_ns = 5000000;
   localparam int unsigned write_cycles  = write_time_ns / clk_period_ns;

   // Geometry
   localparam int unsigned mem_depth  = 1024;
   localparam int unsigned page_bytes = 32;
   localparam int unsigned uid_bytes  = 16;
   localparam int unsigned hdr_bytes  = 3;

   // Instruction codes
   localparam logic [7:0] op_write_status  = 8'h01;
   localparam logic [7:0] op_write         = 8'h02;
   localparam logic [7:0] op_read          = 8'h03;
   localparam logic [7:0] op_write_disable = 8'h04;
   localparam logic [7:0] op_read_status   = 8'h05;
   localparam logic [7:0] op_write_enable  = 8'h06;
   localparam logic [7:0] op_write_sec     = 8'h82;
   localparam logic [7:0] op_read_sec      = 8'h83;

   // Status byte field positions
   localparam int unsigned st_busy     = 0;
   localparam int unsigned st_latch    = 1;
   localparam int unsigned st_guard_lo = 2;
   localparam int unsigned st_guard_hi = 3;
   localparam int unsigned st_lock     = 7;

   // Block guard encodings
   localparam logic [1:0] guard_none    = 2'h0;
   localparam logic [1:0] guard_quarter = 2'h1;
   localparam logic [1:0] guard_half    = 2'h2;
   localparam logic [1:0] guard_all     = 2'h3;

   // Register port offsets, reset values and the byte for unmapped link reads
   localparam logic [7:0]   reg_status   = 8'h00;
   localparam logic [7:0]   reg_uid0     = 8'h08;
   localparam logic [7:0]   reg_uid1     = 8'h0c;
   localparam logic [7:0]   reg_uid2     = 8'h10;
   localparam logic [7:0]   reg_uid3     = 8'h14;
   localparam logic [127:0] uid_reset    = 128'h0;
   localparam logic [7:0]   status_reset = 8'h00;
   localparam logic [7:0]   unmapped_val = 8'hff;

   typedef struct packed {
      logic        started;
      logic [2:0]  bit_pos;
      logic [15:0] byte_cnt;
      logic [6:0]  shin;
   } frame_t;

   typedef struct packed {
      logic        seq;
      logic [7:0]  opcode;
      logic [15:0] addr;
      logic [7:0]  sdata;
      logic [4:0]  ptr;
      logic [31:0] mask;
      logic [15:0] nbytes;
      logic        aligned;
   } cmd_t;

   typedef struct packed {
      logic [6:0] shreg;
      logic       dout;
   } out_t;

   typedef struct packed {
      logic         sel_meta;
      logic         sel_sync;
      logic         sel_prev;
      logic         pin_meta;
      logic         pin_sync;
      logic         armed;
      logic         sel_ok;
      logic         seq_seen;
      logic         latch;
      logic         busy;
      logic         lock;
      logic [1:0]   guard;
      logic [31:0]  timer;
      logic [127:0] unique_identifier;
      logic [31:0]  rdata;
   } mstate_t;

endpackage : spi_eeprom_pkg

// [hdl/spi_eeprom_interface.sv]
// Serial slave front end of a 1 Kbyte nonvolatile memory with sector and id
//
// Overview of operation
// R01: Instruction, address and data bits are taken on each rising link edge.
// R02: Read data and status leave on each falling link edge.
// R03: Select high deselects and floats the output; select low allows work.
// R04: After power-up nothing runs until select has fallen from high.
// R05: Pause low while selected floats output and ignores clock and input.
// R06: Pause release resumes the interrupted transfer with state kept.
// R07: Lock bit 1 with write guard low refuses every status write.
// R08: Bus modes 0 and 3 both work; clock idle level is free.
// R09: Main array holds 1024 bytes, 32 pages of 32, via 0xh codes.
// R10: One write stores a single byte or up to 32 bytes of one page.
// R11: Each write is self timed and ends within 5 ms without clocking.
// R12: Sector reached via 8xh when A10 A9 are 00; A4..A0 pick byte.
// R13: A 128-bit identifier is read via 8xh with the A9 pattern set.
// R14: Software may guard top quarter, top half or all of the array.
// R15: Identifier access needs A9 high; A3..A0 pick the byte.
// R16: Guard 00 none, 01 300-3ff, 10 200-3ff, 11 whole array.
// R17: Write latch clears at power-up, set by enable, clears after a write.
// R18: While busy only the status read runs; busy clears when done.
// R19: Page write byte address wraps inside its own 32-byte page.
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_interface #(
   parameter int unsigned write_cycles = spi_eeprom_pkg::write_cycles
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [31:0] reg_rdata,
   input  wire logic        sclk,
   input  wire logic        select_n,
   input  wire logic        serial_in,
   input  wire logic        pause_n,
   input  wire logic        write_guard_n,
   output var  logic        serial_out,
   output var  logic        serial_out_oe
);

   localparam int unsigned pb = spi_eeprom_pkg::page_bytes;

   // Main and sector arrays live in the system domain; the link side reads them only when
   // no write is running, so they are quasi-static for the reader.
   logic [7:0] main_mem [spi_eeprom_pkg::mem_depth];
   logic [7:0] sec_mem  [pb];
   logic [7:0] page_buf [pb];

   spi_eeprom_pkg::frame_t  f;
   spi_eeprom_pkg::frame_t  next_f;
   spi_eeprom_pkg::cmd_t    c;
   spi_eeprom_pkg::cmd_t    next_c;
   spi_eeprom_pkg::out_t    o;
   spi_eeprom_pkg::out_t    next_o;
   spi_eeprom_pkg::mstate_t s;
   spi_eeprom_pkg::mstate_t next_s;

   logic        frame_rst;
   logic        tri_off;
   logic        pb_we;
   logic [7:0]  next_byte;
   logic [7:0]  status_now;
   logic [7:0]  rd_byte;
   logic [15:0] rd_off;
   logic [9:0]  main_a;
   logic [4:0]  sec_a;
   logic [3:0]  uid_a;
   logic        read_mode;
   logic        load;
   logic        next_oe;
   logic        do_main;
   logic        do_sec;
   logic        hw_locked;

   function automatic logic is_guarded(input logic [1:0] g,
                                       input logic [9:0] a);
      case (g)
         spi_eeprom_pkg::guard_quarter: is_guarded = (a[9:8] == 2'h3);
         spi_eeprom_pkg::guard_half:    is_guarded = a[9];
         spi_eeprom_pkg::guard_all:     is_guarded = 1'b1;
         default:                       is_guarded = 1'b0;
      endcase
   endfunction : is_guarded

   // A write frame must carry at least one data byte after its header
   function automatic logic has_payload(input logic [15:0] n);
      has_payload = (n > 16'(spi_eeprom_pkg::hdr_bytes));
   endfunction : has_payload

   // Status byte seen by both the link and the register port
   always_comb begin
      status_now = spi_eeprom_pkg::status_reset;
      status_now[spi_eeprom_pkg::st_busy]     = s.busy;
      status_now[spi_eeprom_pkg::st_latch]    = s.latch;
      status_now[spi_eeprom_pkg::st_guard_lo] = s.guard[0];
      status_now[spi_eeprom_pkg::st_guard_hi] = s.guard[1];
      status_now[spi_eeprom_pkg::st_lock]     = s.lock;
   end

   // Link side, rising edge: shift in and decode frame bytes
   assign frame_rst = rst | select_n; // [R03]
   assign next_byte = {f.shin, serial_in};

   always_comb begin
      next_f = f;
      next_c = c;
      pb_we  = 1'b0;
      // Edges while deselected, such as a change of idle level between
      // modes, must not be mistaken for a frame and flip its marker
      if (pause_n && !frame_rst) begin // [R03] [R05] [R06] [R08]
         next_f.started = 1'b1;
         if (!f.started) begin
            next_c.seq = ~c.seq;
         end
         next_f.bit_pos = f.bit_pos + 3'h1; // [R01] [R08]
         next_f.shin    = next_byte[6:0];
         if (f.bit_pos == 3'h7) begin
            next_f.byte_cnt = f.byte_cnt + 16'h1;
            case (f.byte_cnt)
               16'h0: next_c.opcode = next_byte;
               16'h1: begin
                  next_c.addr[15:8] = next_byte;
                  next_c.sdata      = next_byte;
               end
               16'h2: begin
                  next_c.addr[7:0] = next_byte;
                  next_c.ptr       = next_byte[4:0];
                  next_c.mask      = '0;
               end
               default: begin
                  pb_we               = 1'b1; // [R10]
                  next_c.mask[c.ptr]  = 1'b1;
                  next_c.ptr          = c.ptr + 5'h1; // [R19]
               end
            endcase
         end
         next_c.nbytes  = next_f.byte_cnt;
         next_c.aligned = (next_f.bit_pos == 3'h0);
      end
   end

   // Frame counters end with the frame; the captured command outlives it
   // so the system side can act on it after select rises.
   always_ff @(posedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         f <= '0;
      end else begin
         f <= next_f;
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   always_ff @(posedge sclk) begin
      if (pb_we) begin
         page_buf[c.ptr] <= next_byte;
      end
   end

   // Link side, falling edge: read source and output shifter
   always_comb begin
      rd_off = f.byte_cnt - 16'(spi_eeprom_pkg::hdr_bytes);
      main_a = c.addr[9:0] + rd_off[9:0];
      sec_a  = c.addr[4:0] + rd_off[4:0];
      uid_a  = c.addr[3:0] + rd_off[3:0];
      case (c.opcode)
         spi_eeprom_pkg::op_read_status: rd_byte = status_now;
         spi_eeprom_pkg::op_read:        rd_byte = main_mem[main_a]; // [R09]
         spi_eeprom_pkg::op_read_sec: begin
            if (c.addr[9]) begin
               rd_byte = s.unique_identifier[{uid_a, 3'h0} +: 8]; // [R13] [R15]
            end else if (c.addr[10:9] == 2'h0) begin
               rd_byte = sec_mem[sec_a]; // [R12]
            end else begin
               rd_byte = spi_eeprom_pkg::unmapped_val;
            end
         end
         default: rd_byte = spi_eeprom_pkg::unmapped_val;
      endcase
      read_mode = 1'b0;
      if (s.sel_ok) begin // [R04]
         if (c.opcode == spi_eeprom_pkg::op_read_status) begin
            read_mode = (f.byte_cnt != 16'h0);
         end else if ((c.opcode == spi_eeprom_pkg::op_read ||
                       c.opcode == spi_eeprom_pkg::op_read_sec) &&
                      !s.busy) begin // [R18]
            read_mode = (f.byte_cnt >= 16'(spi_eeprom_pkg::hdr_bytes));
         end
      end
      load    = read_mode && (f.bit_pos == 3'h0);
      next_oe = read_mode;
      next_o  = o;
      if (pause_n) begin // [R06]
         if (load) begin
            next_o.dout  = rd_byte[7]; // [R02]
            next_o.shreg = rd_byte[6:0];
         end else begin
            next_o.dout  = o.shreg[6];
            next_o.shreg = {o.shreg[5:0], 1'b0};
         end
      end
   end

   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         o <= '0;
      end else begin
         o <= next_o;
      end
   end

   // Enable drops at once on deselect or pause and returns on a falling edge
   assign tri_off = rst | select_n | ~pause_n; // [R03] [R05]

   always_ff @(negedge sclk or posedge tri_off) begin
      if (tri_off) begin
         serial_out_oe <= 1'b0;
      end else begin
         serial_out_oe <= next_oe;
      end
   end

   assign serial_out = o.dout;

   // System side: select and guard synchronisers, command execution, timer
   assign hw_locked = s.lock & ~s.pin_sync;

   always_comb begin
      next_s          = s;
      do_main         = 1'b0;
      do_sec          = 1'b0;
      next_s.sel_meta = select_n;
      next_s.sel_sync = s.sel_meta;
      next_s.sel_prev = s.sel_sync;
      next_s.pin_meta = write_guard_n;
      next_s.pin_sync = s.pin_meta;
      next_s.rdata    = '0;
      if (s.sel_sync) begin
         next_s.armed = 1'b1; // [R04]
      end
      if (s.sel_prev && !s.sel_sync) begin
         next_s.sel_ok = s.armed; // [R04]
      end
      // Every frame is logged, busy or not, so one refused during a write
      // cannot leave the marker of the next frame looking stale
      if (!s.sel_prev && s.sel_sync) begin
         next_s.seq_seen = c.seq;
      end
      if (s.busy) begin
         if (s.timer >= write_cycles - 32'h1) begin
            next_s.busy  = 1'b0; // [R11] [R18]
            next_s.latch = 1'b0; // [R17]
         end else begin
            next_s.timer = s.timer + 32'h1;
         end
      end else if (!s.sel_prev && s.sel_sync) begin
         if (c.seq != s.seq_seen && s.sel_ok && c.aligned) begin
            case (c.opcode)
               spi_eeprom_pkg::op_write_enable: begin
                  if (c.nbytes == 16'h1) begin
                     next_s.latch = 1'b1; // [R17]
                  end
               end
               spi_eeprom_pkg::op_write_disable: begin
                  if (c.nbytes == 16'h1) begin
                     next_s.latch = 1'b0;
                  end
               end
               spi_eeprom_pkg::op_write_status: begin
                  if (c.nbytes == 16'h2 && s.latch && !hw_locked) begin // [R07]
                     next_s.lock     = c.sdata[spi_eeprom_pkg::st_lock];
                     next_s.guard[0] = c.sdata[spi_eeprom_pkg::st_guard_lo];
                     next_s.guard[1] = c.sdata[spi_eeprom_pkg::st_guard_hi];
                     next_s.busy     = 1'b1;
                     next_s.timer    = '0;
                  end
               end
               spi_eeprom_pkg::op_write: begin
                  if (has_payload(c.nbytes) && s.latch &&
                      !is_guarded(s.guard, c.addr[9:0])) begin // [R14] [R16]
                     do_main      = 1'b1;
                     next_s.busy  = 1'b1;
                     next_s.timer = '0;
                  end
               end
               spi_eeprom_pkg::op_write_sec: begin
                  if (has_payload(c.nbytes) && s.latch &&
                      c.addr[10:9] == 2'h0) begin // [R12]
                     do_sec       = 1'b1;
                     next_s.busy  = 1'b1;
                     next_s.timer = '0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (reg_rd) begin
         case (reg_addr)
            spi_eeprom_pkg::reg_status: next_s.rdata = {24'h0, status_now};
            spi_eeprom_pkg::reg_uid0:   next_s.rdata = s.unique_identifier[31:0];
            spi_eeprom_pkg::reg_uid1:   next_s.rdata = s.unique_identifier[63:32];
            spi_eeprom_pkg::reg_uid2:   next_s.rdata = s.unique_identifier[95:64];
            spi_eeprom_pkg::reg_uid3:   next_s.rdata = s.unique_identifier[127:96];
            default:                    next_s.rdata = '0;
         endcase
      end
      if (reg_wr) begin
         case (reg_addr)
            spi_eeprom_pkg::reg_uid0: next_s.unique_identifier[31:0]   = reg_wdata;
            spi_eeprom_pkg::reg_uid1: next_s.unique_identifier[63:32]  = reg_wdata;
            spi_eeprom_pkg::reg_uid2: next_s.unique_identifier[95:64]  = reg_wdata;
            spi_eeprom_pkg::reg_uid3: next_s.unique_identifier[127:96] = reg_wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s       <= '0;
         s.unique_identifier   <= spi_eeprom_pkg::uid_reset;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;

   // Page commit in one cycle; the page buffer is still while select is high
   always_ff @(posedge mclk) begin
      for (int i = 0; i < pb; i++) begin
         if (do_main && c.mask[i]) begin
            main_mem[{c.addr[9:5], 5'(i)}] <= page_buf[i]; // [R10] [R19]
         end
         if (do_sec && c.mask[i]) begin
            sec_mem[i] <= page_buf[i];
         end
      end
   end

endmodule : spi_eeprom_interface

`default_nettype wire

// [sim/spi_eeprom_properties.sv]
// Port-level checker for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_properties #(
   parameter int unsigned write_cycles = 50
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        sclk,
   input wire logic        select_n,
   input wire logic        serial_in,
   input wire logic        pause_n,
   input wire logic        write_guard_n,
   input wire logic        serial_out,
   input wire logic        serial_out_oe
);
   // Select and pause clear the enable asynchronously, so mclk sees it
   deselect_float_a: assert property (@(posedge mclk) disable iff (rst)
      select_n |-> !serial_out_oe) else $error("output driven deselected");
   pause_float_a: assert property (@(posedge mclk) disable iff (rst)
      !pause_n |-> !serial_out_oe) else $error("output driven in pause");
   oe_release_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(serial_out_oe) |-> select_n || !pause_n)
      else $error("output released without cause");
   // Sclk low lasts three mclk periods, so a fall is always seen low
   out_on_fall_a: assert property (@(posedge mclk) disable iff (rst)
      serial_out_oe && $changed(serial_out) |-> !sclk)
      else $error("output changed outside falling edge");
   oe_start_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(serial_out_oe) |-> !sclk && !select_n && pause_n)
      else $error("output enabled at wrong moment");
   uid_readback_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == spi_eeprom_pkg::reg_uid0
      ##2 reg_rd && reg_addr == spi_eeprom_pkg::reg_uid0
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("id word lost");
   rdata_pulse_a: assert property (@(posedge mclk) disable iff (rst)
      !reg_rd |=> reg_rdata == 32'h0) else $error("read data not cleared");
   link_owner_a: assert property (@(posedge sclk) disable iff (rst)
      serial_out_oe |-> !select_n && pause_n)
      else $error("output driven while not owning link");
endmodule : spi_eeprom_properties
bind spi_eeprom_interface spi_eeprom_properties #(
   .write_cycles(write_cycles)
) props (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk),
   .select_n(select_n), .serial_in(serial_in), .pause_n(pause_n),
   .write_guard_n(write_guard_n), .serial_out(serial_out),
   .serial_out_oe(serial_out_oe)
);
`default_nettype wire

// [sim/spi_host_model.sv]
// Bus master model that frames transfers on the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output var  logic sclk,
   output var  logic select_n,
   output var  logic serial_in,
   output var  logic pause_n,
   input  wire logic serial_out,
   input  wire logic serial_out_oe
);
   localparam realtime half = 62.5;
   wire logic line = serial_out_oe ? serial_out : 1'bz;
   initial begin
      sclk = 1'b0;
      select_n = 1'b1;
      serial_in = 1'b0;
      pause_n = 1'b1;
   end
   task automatic frame(input logic m3, input int ntx, input logic [63:0] tx,
         input int nrx, input int hb, output logic [31:0] rx,
         output logic any_oe, output logic hold_oe);
      int nb;
      nb = 8 * (ntx + nrx);
      rx = 32'h0;
      any_oe = 1'b0;
      hold_oe = 1'b0;
      sclk = m3;
      #(half);
      select_n = 1'b0;
      #(half);
      for (int i = 0; i < nb; i++) begin
         sclk = 1'b0;
         if (i == hb) begin
            // Select stays low through the pause; junk edges must be ignored
            // Pause moves off the clock edge so the edge is never raced
            #1 pause_n = 1'b0;
            repeat (3) begin
               #(half) sclk = 1'b1;
               serial_in = ~serial_in;
               hold_oe |= serial_out_oe;
               #(half) sclk = 1'b0;
            end
            #1 pause_n = 1'b1;
         end
         serial_in = (i < 8 * ntx) ? tx[8 * ntx - 1 - i] : 1'b0;
         #(half) sclk = 1'b1;
         if (i >= 8 * ntx) rx = {rx[30:0], line};
         any_oe |= serial_out_oe;
         #(half);
      end
      if (!m3) sclk = 1'b0;
      #(half);
      select_n = 1'b1;
      // Released data line toggles so a stale value is never mistaken
      serial_in = ~serial_in;
      #300;
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
   } row_t;
   // Long enough that a read and a status read fit inside one busy period
   localparam int unsigned wcyc = 600;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        write_guard_n = 1'b1;
   logic [31:0] reg_rdata, v;
   logic        sclk, select_n, serial_in, pause_n;
   logic        serial_out, serial_out_oe, ao, ho;
   int          miscompares = 0;
   int          samples_checked = 0;
   row_t        rows [10] = '{'{1'b0, 8'h08, 32'h0},
      '{1'b1, 8'h08, 32'h33221100}, '{1'b0, 8'h08, 32'h33221100},
      '{1'b1, 8'h0c, 32'h77665544}, '{1'b1, 8'h10, 32'hbbaa9988},
      '{1'b1, 8'h14, 32'hffeeddcc}, '{1'b1, 8'h00, 32'h000000ff},
      '{1'b0, 8'h00, 32'h0}, '{1'b0, 8'h04, 32'h0},
      '{1'b0, 8'h14, 32'hffeeddcc}};
   always #10 mclk = ~mclk;
   spi_eeprom_interface #(.write_cycles(wcyc)) uut (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk),
      .select_n(select_n), .serial_in(serial_in), .pause_n(pause_n),
      .write_guard_n(write_guard_n), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe));
   spi_host_model host (.sclk(sclk), .select_n(select_n),
      .serial_in(serial_in), .pause_n(pause_n), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge mclk);
   endtask : rd
   task automatic st(input logic [7:0] e);
      rd(spi_eeprom_pkg::reg_status, v);
      chk("status", {24'h0, e}, v);
   endtask : st
   task automatic sp(input logic m, input int n, input logic [63:0] t,
         input int nr, input int hb);
      host.frame(m, n, t, nr, hb, v, ao, ho);
      @(posedge mclk);
   endtask : sp
   task automatic idle();
      int k;
      k = 0;
      do begin
         rd(spi_eeprom_pkg::reg_status, v);
         k++;
      end while (v[0] !== 1'b0 && k < 1000);
      chk("busy", 32'h0, {31'h0, v[0]});
   endtask : idle
   task automatic give_verdict();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (5) @(posedge mclk);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].a, rows[i].d);
         end else begin
            rd(rows[i].a, v);
            chk("reg", rows[i].d, v);
         end
      end
      sp(0, 1, 64'h05, 1, -1);
      chk("link status", 32'h0, v);
      sp(1, 1, 64'h06, 0, -1);
      sp(1, 1, 64'h05, 1, -1);
      chk("latch set", 32'h02, v);
      sp(1, 7, 64'h02001ea0a1a2a3, 0, 30);
      idle();
      st(8'h00);
      sp(0, 3, 64'h03001e, 2, -1);
      chk("page head", 32'ha0a1, v);
      sp(0, 3, 64'h030000, 2, -1);
      chk("page wrap", 32'ha2a3, v);
      sp(0, 4, 64'h02000555, 0, -1);
      st(8'h00);
      sp(0, 1, 64'h06, 0, -1);
      sp(0, 2, 64'h0104, 0, -1);
      idle();
      st(8'h04);
      sp(0, 1, 64'h06, 0, -1);
      sp(0, 4, 64'h02030077, 0, -1);
      st(8'h06);
      sp(0, 4, 64'h0202ff66, 0, -1);
      sp(0, 3, 64'h0302ff, 1, -1);
      chk("busy read oe", 32'h0, {31'h0, ao});
      sp(0, 1, 64'h05, 1, -1);
      chk("busy bit", 32'h01, v & 32'h01);
      idle();
      sp(0, 3, 64'h0302ff, 1, -1);
      chk("below guard", 32'h66, v);
      sp(0, 1, 64'h06, 0, -1);
      sp(0, 2, 64'h0184, 0, -1);
      idle();
      write_guard_n <= 1'b0;
      sp(0, 1, 64'h06, 0, -1);
      sp(0, 2, 64'h0100, 0, -1);
      st(8'h86);
      write_guard_n <= 1'b1;
      sp(0, 2, 64'h0100, 0, -1);
      idle();
      st(8'h00);
      sp(0, 1, 64'h06, 0, -1);
      sp(0, 4, 64'h8201035a, 0, -1);
      idle();
      sp(0, 3, 64'h830003, 1, -1);
      chk("sector", 32'h5a, v);
      sp(1, 3, 64'h8302f5, 1, -1);
      chk("id byte", 32'h55, v);
      sp(0, 3, 64'h8302ff, 2, -1);
      chk("id wrap", 32'hff00, v);
      sp(0, 3, 64'h03001e, 2, 28);
      chk("pause oe", 32'h0, {31'h0, ho});
      // The bit under the pause is not driven; the rest must not slip
      chk("pause read", 32'ha0a1, v & 32'hfffff7ff);
      // Reset in mid-run: state clears and a fresh select fall is needed
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(spi_eeprom_pkg::reg_uid1, v);
      chk("id reset", 32'h0, v);
      st(8'h00);
      sp(0, 1, 64'h06, 0, -1);
      sp(0, 1, 64'h05, 1, -1);
      chk("latch after reset", 32'h02, v);
      give_verdict();
   end
   initial begin
      #1ms;
      miscompares++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
